// ---- hw/adcc_cal_bank.sv ----
// Calibration register bank with auto-incrementing pointer
`timescale 1ns/1ps
module adcc_cal_bank
    import adcc_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [1:0] cal_select,
    input wire logic restart,
    input wire logic access_done,
    input wire logic wr_en,
    input wire logic [15:0] wr_data,
    output logic [15:0] rd_data,
    output logic [15:0] gain_trim,
    output logic [15:0] offset_trim
);

    logic [15:0] mem_q [CAL_REGS];
    logic [3:0] ptr_q;

    // First register of a selection
    function automatic logic [3:0] first_idx(input logic [1:0] sel);
        first_idx = (sel == CALSEL_OFS) ? IDX_OFFSET : IDX_GAIN;
    endfunction

    // Last register of a selection
    function automatic logic [3:0] last_idx(input logic [1:0] sel);
        case (sel)
            CALSEL_ALL: last_idx = IDX_DAC_LAST;
            CALSEL_GAIN_OFS: last_idx = IDX_OFFSET;
            CALSEL_OFS: last_idx = IDX_OFFSET;
            default: last_idx = IDX_GAIN;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Pointer
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            ptr_q <= IDX_GAIN;
        else if (restart)
            ptr_q <= first_idx(cal_select);
        else if (access_done)
        begin
            if (ptr_q == last_idx(cal_select))
                ptr_q <= first_idx(cal_select);
            else
                ptr_q <= ptr_q + 4'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Storage
    genvar gi;
    generate
        for (gi = 0; gi < CAL_REGS; gi++)
        begin : g_reg
            always_ff @(posedge core_clk or posedge rst)
            begin
                if (rst)
                    mem_q[gi] <= (gi == int'(IDX_GAIN)) ? GAIN_TRIM_RESET :
                        (gi == int'(IDX_OFFSET)) ? OFFSET_TRIM_RESET :
                        DAC_TRIM_RESET;
                else if (wr_en && ptr_q == 4'(gi))
                    mem_q[gi] <= {2'b00, wr_data[CAL_DATA_W-1:0]};
            end
        end
    endgenerate

    assign rd_data = {2'b00, mem_q[ptr_q][CAL_DATA_W-1:0]};
    assign gain_trim = mem_q[IDX_GAIN];
    assign offset_trim = mem_q[IDX_OFFSET];

endmodule

// ---- hw/adcc_pkg.sv ----
// Shared constants and types for the converter control block
package adcc_pkg;

    // Timing
    localparam int CLK_PERIOD_NS = 100;
    localparam int ACQ_TIME_NS = 400;
    localparam int ACQ_CYCLES = (ACQ_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CAL_TIME_MS = 70;
    localparam int CAL_CYCLES = CAL_TIME_MS * (1000000 / CLK_PERIOD_NS);
    localparam int CONV_TENTHS = 165;
    localparam logic [5:0] CONV_HALF_EDGES = 6'((CONV_TENTHS * 2) / 10);
    localparam int CAL_CNT_W = 20;
    localparam int ACQ_CNT_W = 4;

    // Control word fields
    localparam int CTRL_START_BIT = 0;
    localparam int CTRL_RDT_LO = 1;
    localparam int CTRL_CAL_LO = 3;

    // Read targets
    localparam logic [1:0] RDT_RESULT = 2'h0;
    localparam logic [1:0] RDT_RESULT_ALT = 2'h1;
    localparam logic [1:0] RDT_CAL = 2'h2;
    localparam logic [1:0] RDT_STATUS = 2'h3;

    // Calibration selections and bank layout
    localparam logic [1:0] CALSEL_ALL = 2'h0;
    localparam logic [1:0] CALSEL_GAIN_OFS = 2'h1;
    localparam logic [1:0] CALSEL_OFS = 2'h2;
    localparam logic [1:0] CALSEL_GAIN = 2'h3;
    localparam int CAL_REGS = 10;
    localparam logic [3:0] IDX_GAIN = 4'h0;
    localparam logic [3:0] IDX_OFFSET = 4'h1;
    localparam logic [3:0] IDX_DAC_LAST = 4'h9;
    localparam int CAL_DATA_W = 14;
    localparam logic [15:0] OFFSET_TRIM_RESET = 16'h2000;
    localparam logic [15:0] GAIN_TRIM_RESET = 16'h2000;
    localparam logic [15:0] DAC_TRIM_RESET = 16'h0000;

    // Status word fields
    localparam int STAT_START_BIT = 0;
    localparam int STAT_CAL_LO = 1;
    localparam int STAT_BUSY_BIT = 3;
    localparam int STAT_SELFCAL_BIT = 4;

    typedef struct packed {
        logic [1:0] cal_select;
        logic [1:0] read_target;
        logic soft_start;
    } adcc_ctrl_type;

    typedef enum logic [2:0] {
        ADCC_IDLE = 3'h0,
        ADCC_WAIT_EDGE = 3'h1,
        ADCC_CONVERT = 3'h3,
        ADCC_ACQUIRE = 3'h2,
        ADCC_SELF_CAL = 3'h6
    } adcc_state_type;

endpackage

// ---- hw/adcc_top.sv ----
// Converter control: bus, calibration access, conversion timing
//
// Overview of operation
// - Cal select picks ten, two, or one registers
// - Selection applies to reads and writes
// - Read target 10 returns calibration data
// - Pointer restarts on control write or wrap
// - Pointer starts at gain, offset-only excepted
// - Pointer advances after each complete access
// - Byte mode advances after upper byte
// - Sequences may stop early; control write resets
// - Calibration reads show two zero MSBs
// - Offset register: 14 data bits
// - Offset default about bit 13 set
// - Offset bits binary weighted, top 5%
// - Gain register: 14 bits, top 2.5%
// - Start by pin low pulse or soft bit
// - Hold on pin rise or write end
// - Convert 16.5 periods, 17.5 when late
// - Busy falls when result is ready
// - Busy fall clears soft start bit
// - First start runs long self-calibration
// - Track on busy fall, 400 ns acquire
`timescale 1ns/1ps
module adcc_top
    import adcc_pkg::*;
#(
    parameter int CAL_WAIT_CYCLES = CAL_CYCLES
)
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic cs_n,
    input wire logic rd_n,
    input wire logic wr_n,
    input wire logic data_port_select,
    input wire logic byte_mode,
    input wire logic upper_byte_select,
    input wire logic [15:0] data_in,
    output logic [15:0] data_out,
    output logic data_oe,
    input wire logic conversion_start_n,
    input wire logic master_clock_in,
    input wire logic [11:0] conv_code_in,
    output logic busy,
    output logic track_hold,
    output logic self_cal_active,
    output logic [15:0] gain_trim_out,
    output logic [15:0] offset_trim_out
);

    ////////////////////////////////////////////////////////////////////////
    // Declarations
    adcc_ctrl_type ctrl_q;
    adcc_state_type state_q;
    logic rd_act_q;
    logic wr_act_q;
    logic port_q;
    logic hbe_q;
    logic [15:0] din_q;
    logic [7:0] low_stage_q;
    logic start_pin_q;
    logic mclk_q;
    logic fresh_q;
    logic pending_q;
    logic cal_done_q;
    logic self_cal_q;
    logic [5:0] edge_cnt_q;
    logic [ACQ_CNT_W-1:0] acq_cnt_q;
    logic [CAL_CNT_W-1:0] cal_cnt_q;
    logic [11:0] result_q;
    logic [15:0] data_out_q;
    logic data_oe_q;
    logic busy_q;
    logic hold_q;
    logic [15:0] gain_q;
    logic [15:0] offset_q;
    logic rd_now;
    logic wr_now;
    logic rd_end;
    logic wr_end;
    logic ctrl_wr;
    logic data_wr;
    logic full_word;
    logic cal_wr_en;
    logic cal_done_access;
    logic [15:0] cal_wdata;
    logic [15:0] cal_rdata;
    logic [15:0] gain_w;
    logic [15:0] offset_w;
    logic pin_rise;
    logic soft_go;
    logic start_evt;
    logic mclk_fall;
    logic mclk_edge;
    logic conv_end;
    logic acq_end;
    logic busy_fall;
    logic [15:0] word_sel;
    logic [15:0] status_w;

    // Detects end of an access strobe
    function automatic logic strobe_end(input logic was, input logic now);
        strobe_end = was && !now;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Bus strobes
    assign rd_now = !cs_n && !rd_n;
    assign wr_now = !cs_n && !wr_n;
    assign rd_end = strobe_end(rd_act_q, rd_now);
    assign wr_end = strobe_end(wr_act_q, wr_now);
    assign ctrl_wr = wr_end && !port_q;
    assign data_wr = wr_end && port_q;
    assign full_word = !byte_mode || hbe_q;

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            rd_act_q <= 1'b0;
            wr_act_q <= 1'b0;
        end
        else
        begin
            rd_act_q <= rd_now;
            wr_act_q <= wr_now;
        end
    end

    // Access attributes held through the strobe
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            port_q <= 1'b0;
            hbe_q <= 1'b0;
            din_q <= 16'h0000;
        end
        else if (rd_now || wr_now)
        begin
            port_q <= data_port_select;
            hbe_q <= upper_byte_select;
            din_q <= data_in;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Control register; a new soft start set wins over the busy-fall clear
    assign soft_go = ctrl_wr && din_q[CTRL_START_BIT] && !ctrl_q.soft_start;

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            ctrl_q.cal_select <= CALSEL_ALL;
            ctrl_q.read_target <= RDT_RESULT;
            ctrl_q.soft_start <= 1'b0;
        end
        else
        begin
            if (ctrl_wr)
            begin
                ctrl_q.cal_select <= din_q[CTRL_CAL_LO +: 2];
                ctrl_q.read_target <= din_q[CTRL_RDT_LO +: 2];
            end
            if (soft_go)
                ctrl_q.soft_start <= 1'b1;
            else if (busy_fall)
                ctrl_q.soft_start <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Calibration access
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            low_stage_q <= 8'h00;
        else if (data_wr && byte_mode && !hbe_q)
            low_stage_q <= din_q[7:0];
    end

    assign cal_wdata = byte_mode ? {din_q[7:0], low_stage_q} : din_q;
    assign cal_wr_en = data_wr && full_word;
    assign cal_done_access = full_word && ((data_wr) ||
        (rd_end && port_q && ctrl_q.read_target == RDT_CAL));

    adcc_cal_bank u_cal_bank (
        .core_clk(core_clk),
        .rst(rst),
        .cal_select(ctrl_wr ? din_q[CTRL_CAL_LO +: 2] :
            ctrl_q.cal_select),
        .restart(ctrl_wr),
        .access_done(cal_done_access),
        .wr_en(cal_wr_en),
        .wr_data(cal_wdata),
        .rd_data(cal_rdata),
        .gain_trim(gain_w),
        .offset_trim(offset_w)
    );

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            gain_q <= GAIN_TRIM_RESET;
            offset_q <= OFFSET_TRIM_RESET;
        end
        else
        begin
            gain_q <= gain_w;
            offset_q <= offset_w;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read data path
    always_comb
    begin
        status_w = 16'h0000;
        status_w[STAT_START_BIT] = ctrl_q.soft_start;
        status_w[STAT_CAL_LO +: 2] = ctrl_q.cal_select;
        status_w[STAT_BUSY_BIT] = busy_q;
        status_w[STAT_SELFCAL_BIT] = (state_q == ADCC_SELF_CAL);
        case (ctrl_q.read_target)
            RDT_CAL: word_sel = cal_rdata;
            RDT_STATUS: word_sel = status_w;
            RDT_RESULT_ALT: word_sel = {4'h0, result_q};
            default: word_sel = {4'h0, result_q};
        endcase
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            data_out_q <= 16'h0000;
            data_oe_q <= 1'b0;
        end
        else
        begin
            data_oe_q <= rd_now && data_port_select;
            if (byte_mode)
                data_out_q <= {8'h00, upper_byte_select ?
                    word_sel[15:8] : word_sel[7:0]};
            else
                data_out_q <= word_sel;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Start detection and master clock edges
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            start_pin_q <= 1'b1;
            mclk_q <= 1'b0;
        end
        else
        begin
            start_pin_q <= conversion_start_n;
            mclk_q <= master_clock_in;
        end
    end

    assign pin_rise = !start_pin_q && conversion_start_n;
    assign start_evt = pin_rise || soft_go;
    assign mclk_fall = mclk_q && !master_clock_in;
    assign mclk_edge = mclk_q != master_clock_in;
    assign conv_end = (state_q == ADCC_CONVERT) && mclk_edge &&
        (edge_cnt_q == CONV_HALF_EDGES - 6'h01);
    assign acq_end = (state_q == ADCC_ACQUIRE) &&
        (acq_cnt_q == ACQ_CNT_W'(ACQ_CYCLES - 1));
    assign busy_fall = conv_end;

    ////////////////////////////////////////////////////////////////////////
    // Conversion sequencer
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            state_q <= ADCC_IDLE;
        else
        begin
            case (state_q)
                ADCC_IDLE:
                    if (start_evt || pending_q)
                        state_q <= cal_done_q ? ADCC_WAIT_EDGE :
                            ADCC_SELF_CAL;
                ADCC_SELF_CAL:
                    if (cal_cnt_q == CAL_CNT_W'(CAL_WAIT_CYCLES - 1))
                        state_q <= ADCC_WAIT_EDGE;
                ADCC_WAIT_EDGE:
                    if (mclk_fall && !fresh_q)
                        state_q <= ADCC_CONVERT;
                ADCC_CONVERT:
                    if (conv_end)
                        state_q <= ADCC_ACQUIRE;
                ADCC_ACQUIRE:
                    if (acq_end)
                        state_q <= ADCC_IDLE;
                default:
                    state_q <= ADCC_IDLE;
            endcase
        end
    end

    // A start edge in the same cycle as a clock fall misses that fall
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            fresh_q <= 1'b0;
        else
            fresh_q <= (state_q != ADCC_WAIT_EDGE) &&
                (start_evt || pending_q) && mclk_fall;
    end

    // Start during acquisition waits for it to end
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            pending_q <= 1'b0;
        else if (state_q == ADCC_ACQUIRE && start_evt)
            pending_q <= 1'b1;
        else if (state_q == ADCC_IDLE)
            pending_q <= 1'b0;
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            cal_done_q <= 1'b0;
            self_cal_q <= 1'b0;
        end
        else
        begin
            self_cal_q <= (state_q == ADCC_SELF_CAL);
            if (state_q == ADCC_SELF_CAL)
                cal_done_q <= 1'b1;
        end
    end

    // Counters
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            edge_cnt_q <= 6'h00;
        else if (state_q != ADCC_CONVERT)
            edge_cnt_q <= 6'h00;
        else if (mclk_edge)
            edge_cnt_q <= edge_cnt_q + 6'h01;
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            acq_cnt_q <= '0;
        else if (state_q != ADCC_ACQUIRE)
            acq_cnt_q <= '0;
        else
            acq_cnt_q <= acq_cnt_q + ACQ_CNT_W'(1);
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            cal_cnt_q <= '0;
        else if (state_q != ADCC_SELF_CAL)
            cal_cnt_q <= '0;
        else
            cal_cnt_q <= cal_cnt_q + CAL_CNT_W'(1);
    end

    ////////////////////////////////////////////////////////////////////////
    // Busy, track/hold and result
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            busy_q <= 1'b0;
        else if (conv_end)
            busy_q <= 1'b0;
        else if (state_q == ADCC_IDLE && (start_evt || pending_q))
            busy_q <= 1'b1;
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            hold_q <= 1'b0;
        else if (conv_end)
            hold_q <= 1'b0;
        else if (state_q == ADCC_IDLE && (start_evt || pending_q))
            hold_q <= 1'b1;
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            result_q <= 12'h000;
        else if (conv_end)
            result_q <= conv_code_in;
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs
    assign data_out = data_out_q;
    assign data_oe = data_oe_q;
    assign busy = busy_q;
    assign track_hold = hold_q;
    assign self_cal_active = self_cal_q;
    assign gain_trim_out = gain_q;
    assign offset_trim_out = offset_q;

endmodule

// ---- testbench/adcc_host_model.sv ----
// Host processor model: parallel bus and start pin
`timescale 1ns/1ps
module adcc_host_model
    import adcc_pkg::*;
(
    input wire logic core_clk,
    input wire logic busy,
    input wire logic [15:0] data_out,
    output logic cs_n,
    output logic rd_n,
    output logic wr_n,
    output logic data_port_select,
    output logic upper_byte_select,
    output logic [15:0] data_in,
    output logic conversion_start_n
);
    initial
    begin
        {cs_n, rd_n, wr_n, conversion_start_n} = 4'hF;
        {data_port_select, upper_byte_select, data_in} = 18'h00000;
    end
    // One access, one direction only, idle while converting
    task automatic access(input logic wr, dps, ub, input logic [15:0] din,
        output logic [15:0] dout);
        while (busy === 1'b1) @(posedge core_clk);
        @(posedge core_clk);
        #1;
        cs_n = 1'b0;
        rd_n = wr;
        wr_n = !wr;
        data_port_select = dps;
        upper_byte_select = ub;
        data_in = din;
        repeat (2) @(posedge core_clk);
        #1;
        dout = data_out;
        {cs_n, rd_n, wr_n} = 3'h7;
        data_in = ~data_in;
        data_port_select = !dps;
    endtask
    // Low pulse on the start pin
    task automatic start_pulse();
        while (busy === 1'b1) @(posedge core_clk);
        @(posedge core_clk);
        #1;
        conversion_start_n = 1'b0;
        repeat (2) @(posedge core_clk);
        #1;
        conversion_start_n = 1'b1;
    endtask
    // Control write held past the busy fall
    task automatic held_write(input logic [15:0] din);
        @(posedge core_clk);
        #1;
        {cs_n, wr_n, data_port_select} = 3'h0;
        data_in = din;
        do
        begin
            @(posedge core_clk);
            #1;
        end
        while (busy !== 1'b0);
        {cs_n, wr_n} = 2'h3;
    endtask
endmodule

// ---- testbench/adcc_top_props.sv ----
// Port-level checker for the converter control block
`timescale 1ns/1ps
module adcc_top_props
    import adcc_pkg::*;
#(
    parameter int CAL_WAIT_CYCLES = CAL_CYCLES
)
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic cs_n,
    input wire logic rd_n,
    input wire logic wr_n,
    input wire logic data_port_select,
    input wire logic byte_mode,
    input wire logic conversion_start_n,
    input wire logic [15:0] data_out,
    input wire logic data_oe,
    input wire logic busy,
    input wire logic track_hold,
    input wire logic self_cal_active,
    input wire logic [15:0] gain_trim_out,
    input wire logic [15:0] offset_trim_out
);
    // Master clock half period in core cycles, set by the bench
    localparam int MCLK_HALF = 2;
    localparam int CONV_MIN = 33 * MCLK_HALF - 1;
    localparam int BUSY_MAX = CAL_WAIT_CYCLES + 36 * MCLK_HALF + 4;
    logic [15:0] busy_cnt_q;
    wire rd_act = !cs_n && !rd_n && data_port_select;
    wire wr_act = !cs_n && !wr_n;
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            busy_cnt_q <= 16'h0000;
        else if (busy)
            busy_cnt_q <= busy_cnt_q + 16'h0001;
        else
            busy_cnt_q <= 16'h0000;
    end
    ////////////////////////////////////////////////////////////////////////
    a_oe_on_read: assert property (rd_act |=> data_oe)
        else $error("data_oe missing after read");
    a_oe_off_idle: assert property (!rd_act |=> !data_oe)
        else $error("data_oe high without read");
    a_byte_upper_zero: assert property ($past(byte_mode) && byte_mode
        |-> data_out[15:8] == 8'h00)
        else $error("byte mode upper half not zero");
    a_trim_top_zero: assert property (gain_trim_out[15:14] == 2'h0
        && offset_trim_out[15:14] == 2'h0)
        else $error("trim register top bits set");
    a_trim_by_write: assert property (!busy && !$past(busy, 2)
        && (!$stable(gain_trim_out) || !$stable(offset_trim_out))
        |-> $past(wr_act) || $past(wr_act, 2) || $past(wr_act, 3)
        || $past(wr_act, 4))
        else $error("trim changed without write");
    a_hold_on_start: assert property ($rose(busy) |-> track_hold)
        else $error("no hold at start");
    a_track_at_end: assert property ($fell(busy) |-> !track_hold)
        else $error("still holding after busy fell");
    a_pin_starts: assert property ($rose(conversion_start_n) && !busy
        |-> ##[1:8] busy)
        else $error("pin start ignored");
    a_conv_min: assert property ($fell(busy) |-> busy_cnt_q >= CONV_MIN)
        else $error("conversion too short");
    a_busy_max: assert property (busy_cnt_q <= BUSY_MAX)
        else $error("busy too long");
    a_acq_gap: assert property ($fell(busy) |-> !busy [*4])
        else $error("acquisition shorter than 400 ns");
    a_selfcal_busy: assert property (self_cal_active |-> busy)
        else $error("self calibration without busy");
    cover property ($rose(busy));
    cover property ($rose(self_cal_active));
    cover property (byte_mode && data_oe);
endmodule
bind adcc_top adcc_top_props #(.CAL_WAIT_CYCLES(CAL_WAIT_CYCLES))
    adcc_top_props_inst (.core_clk, .rst, .cs_n, .rd_n, .wr_n,
    .data_port_select, .byte_mode, .conversion_start_n, .data_out,
    .data_oe, .busy, .track_hold, .self_cal_active, .gain_trim_out,
    .offset_trim_out);

// ---- testbench/tb.sv ----
// Self-checking bench for the converter control block
`timescale 1ns/1ps
module tb;
    import adcc_pkg::*;
    logic core_clk, rst, cs_n, rd_n, wr_n, data_port_select, byte_mode;
    logic upper_byte_select, data_oe, conversion_start_n, master_clock_in;
    logic busy, track_hold, self_cal_active;
    logic [15:0] data_in, data_out, gain_trim_out, offset_trim_out, rd;
    logic [11:0] conv_code_in;
    int miscompares, checks_done, cyc, n;
    logic [1:0] rsel [5] = '{CALSEL_GAIN, CALSEL_OFS, CALSEL_GAIN_OFS,
        CALSEL_GAIN_OFS, CALSEL_GAIN_OFS};
    int rcnt [5] = '{1, 2, 3, 1, 2};
    logic [15:0] rval [5][3] = '{'{16'h1234, 16'h0000, 16'h0000},
        '{16'h0567, 16'h0999, 16'h0000}, '{16'h0ABC, 16'h0DEF, 16'h0AAA},
        '{16'h0321, 16'h0000, 16'h0000}, '{16'h0444, 16'h0555, 16'h0000}};
    logic [15:0] rgain [5] = '{16'h1234, 16'h1234, 16'h0AAA, 16'h0321,
        16'h0444};
    logic [15:0] rofs [5] = '{16'h0111, 16'h0999, 16'h0DEF, 16'h0DEF,
        16'h0555};
    adcc_top #(.CAL_WAIT_CYCLES(20)) adcc_top_inst (.core_clk, .rst, .cs_n,
        .rd_n, .wr_n, .data_port_select, .byte_mode, .upper_byte_select,
        .data_in, .data_out, .data_oe, .conversion_start_n,
        .master_clock_in, .conv_code_in, .busy, .track_hold,
        .self_cal_active, .gain_trim_out, .offset_trim_out);
    adcc_host_model adcc_host_model_inst (.core_clk, .busy, .data_out,
        .cs_n, .rd_n, .wr_n, .data_port_select, .upper_byte_select,
        .data_in, .conversion_start_n);
    ////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [15:0] seen, exp);
        checks_done++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic conclude();
        $display("miscompares %0d checks_done %0d", miscompares, checks_done);
        if (miscompares == 0 && checks_done > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    function automatic logic [15:0] cw(logic [1:0] s, t, logic st);
        return {11'h000, s, t, st};
    endfunction
    task automatic ctrl(input logic [15:0] w);
        adcc_host_model_inst.access(1'b1, 1'b0, 1'b0, w, rd);
    endtask
    task automatic cal_wr(input logic [15:0] w, input logic ub);
        adcc_host_model_inst.access(1'b1, 1'b1, ub, w, rd);
    endtask
    task automatic rdp(input logic ub);
        adcc_host_model_inst.access(1'b0, 1'b1, ub, 16'h0000, rd);
    endtask
    task automatic settle();
        repeat (3) @(posedge core_clk);
        #1;
    endtask
    task automatic wait_idle(output int k);
        k = 0;
        while (busy !== 1'b0 && k < 500)
        begin
            @(posedge core_clk);
            #1;
            k++;
        end
        check("busy end", {15'h0000, busy}, 16'h0000);
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end
    initial
    begin
        master_clock_in = 1'b0;
        #37;
        forever #200 master_clock_in = ~master_clock_in;
    end
    always @(posedge core_clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            miscompares++;
            conclude();
        end
    end
    initial
    begin
        rst = 1'b1;
        byte_mode = 1'b0;
        conv_code_in = 12'hA5C;
        repeat (16) @(posedge core_clk);
        #1;
        rst = 1'b0;
        check("data_out", data_out, 16'h0000);
        check("offset reset", offset_trim_out, OFFSET_TRIM_RESET);
        check("gain reset", gain_trim_out, GAIN_TRIM_RESET);
        ctrl(cw(CALSEL_ALL, RDT_CAL, 1'b0));
        for (int i = 0; i < 11; i++)
        begin
            rdp(1'b0);
            check("default", rd, (i % 10 < 2) ? 16'h2000 : 16'h0000);
        end
        ctrl(cw(CALSEL_ALL, RDT_RESULT, 1'b0));
        for (int i = 0; i < 10; i++)
            cal_wr(16'hC000 | 16'(i * 16'h0111), 1'b0);
        ctrl(cw(CALSEL_ALL, RDT_CAL, 1'b0));
        for (int i = 0; i < 10; i++)
        begin
            rdp(1'b0);
            check("readback", rd, 16'(i * 16'h0111));
        end
        check("offset out", offset_trim_out, 16'h0111);
        for (int r = 0; r < 5; r++)
        begin
            ctrl(cw(rsel[r], RDT_CAL, 1'b0));
            for (int i = 0; i < rcnt[r]; i++)
                cal_wr(rval[r][i], 1'b0);
            settle();
            check("gain row", gain_trim_out, rgain[r]);
            check("offset row", offset_trim_out, rofs[r]);
            ctrl(cw(rsel[r], RDT_CAL, 1'b0));
            rdp(1'b0);
            check("first", rd, rsel[r] == CALSEL_OFS ? rofs[r] : rgain[r]);
        end
        byte_mode = 1'b1;
        ctrl(cw(CALSEL_GAIN, RDT_RESULT, 1'b0));
        cal_wr(16'h0056, 1'b0);
        settle();
        check("gain low byte", gain_trim_out, 16'h0444);
        cal_wr(16'h0007, 1'b1);
        settle();
        check("gain upper byte", gain_trim_out, 16'h0756);
        ctrl(cw(CALSEL_GAIN_OFS, RDT_CAL, 1'b0));
        rdp(1'b0);
        check("byte 0", rd, 16'h0056);
        rdp(1'b1);
        check("byte 1", rd, 16'h0007);
        rdp(1'b0);
        check("byte 2", rd, 16'h0055);
        byte_mode = 1'b0;
        adcc_host_model_inst.start_pulse();
        repeat (2) @(posedge core_clk);
        #1;
        check("self cal", {15'h0000, self_cal_active}, 16'h0001);
        wait_idle(n);
        adcc_host_model_inst.start_pulse();
        repeat (2) @(posedge core_clk);
        #1;
        check("hold", {15'h0000, busy, track_hold}, 16'h0003);
        wait_idle(n);
        check("length", {15'h0000, n >= 64 && n <= 72}, 16'h0001);
        check("track", {15'h0000, track_hold}, 16'h0000);
        ctrl(cw(CALSEL_ALL, RDT_RESULT, 1'b0));
        rdp(1'b0);
        check("result", rd, 16'h0A5C);
        for (int k = 0; k < 2; k++)
        begin
            ctrl(cw(CALSEL_ALL, RDT_STATUS, 1'b1));
            repeat (2) @(posedge core_clk);
            #1;
            check("soft busy", {15'h0000, busy}, 16'h0001);
            wait_idle(n);
            rdp(1'b0);
            check("status", rd & 16'h0009, 16'h0000);
        end
        ctrl(cw(CALSEL_ALL, RDT_STATUS, 1'b1));
        adcc_host_model_inst.held_write(cw(CALSEL_ALL, RDT_STATUS, 1'b1));
        repeat (2) settle();
        check("held start", {15'h0000, busy}, 16'h0001);
        wait_idle(n);
        conclude();
    end
endmodule
